/* File: rtl/meim_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts for the event mask block.
// Assumes: Word-indexed register port; one register per index.
// Notes: Included by the package and the design modules.
`ifndef MEIM_DEFS_SVH
`define MEIM_DEFS_SVH

// =====================================================================
// Register indexes
// =====================================================================
`define MEIM_ADDR_W 16
`define MEIM_OFF_MASK_ONE 16'he50a
`define MEIM_OFF_MASK_TWO 16'he50b
`define MEIM_OFF_STATUS_ONE 16'he502
`define MEIM_OFF_STATUS_TWO 16'he503
`define MEIM_OFF_ACCUMULATION_MODE_REG 16'he701
`define MEIM_OFF_PULSE_OUTPUT_CONFIG_REG 16'he610
`define MEIM_OFF_IRQ_STATUS 16'he5f0
`define MEIM_OFF_IRQ_MASK 16'he5f1

// =====================================================================
// Field positions
// =====================================================================
`define MEIM_BIT_PSUM1 9
`define MEIM_BIT_REVRP_A 10
`define MEIM_BIT_PSUM2 13
`define MEIM_BIT_CF1 14
`define MEIM_BIT_COMPUTE_DONE_EN 17
`define MEIM_BIT_PSUM3 18
`define MEIM_MASK_ONE_LIVE 32'h0007fe00
`define MEIM_MASK_ONE_KEEP 32'h0007ffff
`define MEIM_BIT_NO_LOAD_TOTAL_EN 0
`define MEIM_BIT_NO_LOAD_FUNDAMENTAL_EN 1
`define MEIM_BIT_NO_LOAD_APPARENT_EN 2
`define MEIM_BIT_MISSING_CROSSING_VOLT_A_EN 3
`define MEIM_BIT_MISSING_CROSSING_VOLT_B_EN 4
`define MEIM_MASK_TWO_LIVE 32'h0000001f
`define MEIM_BIT_REACTIVE_SIGN_SOURCE_SEL 7
`define MEIM_BIT_PULSE_OUT_ONE_DISABLE 9
`define MEIM_PULSE_OUTPUT_CONFIG_REG_KEEP 32'h00000fff
`define MEIM_ACCUMULATION_MODE_REG_KEEP 32'h000000ff

// =====================================================================
// Reset values and timing
// =====================================================================
`define MEIM_RST_WORD 32'h00000000
`define MEIM_RST_PULSE_OUTPUT_CONFIG_REG 32'h00000e88
`define MEIM_CLK_HZ 100000000
`define MEIM_DSP_RATE_HZ 8000
`define MEIM_DSP_CYCLES (`MEIM_CLK_HZ / `MEIM_DSP_RATE_HZ)

`endif

/* File: rtl/meim_pkg.sv */
// Purpose: Types shared by the event mask block.
// Assumes: Constants come from meim_defs.svh.
// Notes: None.
`include "meim_defs.svh"

package meim_pkg;
    typedef logic [31:0] meim_word_t;
    typedef logic [`MEIM_ADDR_W-1:0] meim_addr_t;
    typedef logic [2:0] meim_sel_t;
endpackage : meim_pkg

/* File: rtl/meim_edge_watch.sv */
// Purpose: Catches falling edges of the pulse outputs and sign flips of the watched powers.
// Assumes: All inputs synchronous to i_clock.
// Notes: One output pulse per detected event, one cycle after the input change.
`include "meim_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module meim_edge_watch #(
    parameter int WIDTH = 9,
    parameter logic [8:0] FALL_ONLY = 9'h000
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_level,
    output logic [WIDTH-1:0] o_event
);
    import meim_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] last;
        logic [WIDTH-1:0] seen;
        logic [WIDTH-1:0] evt;
    } meim_ew_state_t;

    meim_ew_state_t state_reg;
    meim_ew_state_t state_next;

    // =================================================================
    // Per-bit detection
    // =================================================================
    always_comb begin
        state_next = state_reg;
        state_next.last = i_level;
        state_next.seen = '1;
        for (int k = 0; k < WIDTH; k++) begin
            if (FALL_ONLY[k]) begin
                state_next.evt[k] = state_reg.seen[k] & state_reg.last[k] & ~i_level[k];
            end else begin
                state_next.evt[k] = state_reg.seen[k] & (state_reg.last[k] ^ i_level[k]);
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_event = state_reg.evt;
endmodule : meim_edge_watch

`default_nettype wire

/* File: rtl/meim_event_mask.sv */
// Purpose: Event flags and enable masks of a polyphase meter, with one level interrupt per mask.
// Assumes: Word-indexed register port; reads answer one cycle after the strobe.
// Notes: One rule to a line below.
// Function
// RULE_01: Enable bits 10-12 of mask one pass reactive-power sign flips of phases A-C, source chosen by accumulation mode bit 7.
// RULE_02: Enable bit 13 of mask one passes sign flips of the summed power of pulse path two.
// RULE_03: Enable bit 18 of mask one passes sign flips of the summed power of pulse path three.
// RULE_04: Enable bits 14-16 of mask one pass each falling edge of pulse outputs one to three.
// RULE_05: Pulse-output events still fire while the pin is disabled by configuration bits 9-11.
// RULE_06: Each pulse output follows the power chosen by its three-bit select field in the configuration register.
// RULE_07: Enable bit 17 of mask one passes the completion of each 8 kHz computation pass.
// RULE_08: Bits 31 to 19 of mask one are reserved, reset to zero and have no effect when written.
// RULE_09: Without reactive measurement the reactive sign enables stay writable but never raise an interrupt.
// RULE_10: Enable bit 0 of mask two passes a no-load entry judged on total powers.
// RULE_11: Enable bit 1 of mask two passes a no-load entry on fundamental powers, ineffective without that measurement.
// RULE_12: Enable bit 2 of mask two passes a no-load entry judged on apparent power.
// RULE_13: Enable bits 3 and 4 of mask two pass a missing voltage zero crossing on phase A or B.
// RULE_14: Enable bit 9 of mask one passes sign flips of the summed power of pulse path one.
// RULE_15: Each mask's request is high while a set flag has its enable set; the enable never alters the flag.
// RULE_16: Mask bits read back as last written, including bits inert on the fitted variant; mask one bits 31 to 19 read back as zero.
//
// Chosen here: strobed register access.
`include "meim_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module meim_event_mask #(
    parameter bit HAS_REACTIVE = 1'b1,
    parameter bit HAS_FUNDAMENTAL = 1'b1,
    parameter int DSP_CYCLES = `MEIM_DSP_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire meim_pkg::meim_addr_t i_addr,
    input wire meim_pkg::meim_word_t i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output meim_pkg::meim_word_t o_rdata,
    input wire logic [2:0] i_reactive_total,
    input wire logic [2:0] i_reactive_fund,
    input wire logic [7:0] i_power_sign,
    input wire logic [7:0] i_pulse_req,
    input wire logic [2:0] i_no_load,
    input wire logic [1:0] i_zx_missing,
    output logic [2:0] o_pulse_out,
    output logic [2:0] o_pulse_out_oe,
    output logic o_irq_one,
    output logic o_irq_two,
    output logic o_irq
);
    import meim_pkg::*;

    typedef struct packed {
        meim_word_t mask_one;
        meim_word_t mask_two;
        meim_word_t status_one;
        meim_word_t status_two;
        meim_word_t accumulation_mode_reg;
        meim_word_t pulse_output_config_reg;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic [2:0] pulse;
        logic [13:0] tick_cnt;
        meim_word_t rdata;
    } meim_state_t;

    meim_state_t state_reg;
    meim_state_t state_next;

    logic [8:0] watch_level;
    logic [8:0] watch_event;
    logic [2:0] rp_sign;
    logic [2:0] path_sign;
    logic [2:0] pulse_level;
    logic dsp_done;
    logic irq_one_level;
    logic irq_two_level;
    meim_word_t set_one;
    meim_word_t set_two;
    meim_word_t ena_one;
    meim_word_t ena_two;

    // =================================================================
    // Event sources
    // =================================================================
    assign rp_sign = state_reg.accumulation_mode_reg[`MEIM_BIT_REACTIVE_SIGN_SOURCE_SEL] ? i_reactive_fund : i_reactive_total; // RULE_01

    // Each pulse path's summed-power sign and pulse follow its select field.
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            path_sign[p] = i_power_sign[state_reg.pulse_output_config_reg[3*p +: 3]]; // RULE_06
            pulse_level[p] = ~i_pulse_req[state_reg.pulse_output_config_reg[3*p +: 3]]; // RULE_06
        end
    end

    assign watch_level = {pulse_level, path_sign, rp_sign};

    meim_edge_watch #(
        .WIDTH(9),
        .FALL_ONLY(9'h1c0)
    ) u_watch (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_level(watch_level),
        .o_event(watch_event)
    );

    assign dsp_done = (state_reg.tick_cnt == 14'(DSP_CYCLES - 1));

    // Flag set vectors for both status words.
    always_comb begin
        set_one = '0;
        set_two = '0;
        set_one[`MEIM_BIT_REVRP_A +: 3] = HAS_REACTIVE ? watch_event[2:0] : 3'h0; // RULE_09
        set_one[`MEIM_BIT_PSUM1] = watch_event[3]; // RULE_14
        set_one[`MEIM_BIT_PSUM2] = watch_event[4]; // RULE_02
        set_one[`MEIM_BIT_PSUM3] = watch_event[5]; // RULE_03
        set_one[`MEIM_BIT_CF1 +: 3] = watch_event[8:6]; // RULE_04 RULE_05
        set_one[`MEIM_BIT_COMPUTE_DONE_EN] = dsp_done; // RULE_07
        set_two[`MEIM_BIT_NO_LOAD_TOTAL_EN] = i_no_load[0]; // RULE_10
        set_two[`MEIM_BIT_NO_LOAD_FUNDAMENTAL_EN] = HAS_FUNDAMENTAL & i_no_load[1]; // RULE_11
        set_two[`MEIM_BIT_NO_LOAD_APPARENT_EN] = i_no_load[2]; // RULE_12
        set_two[`MEIM_BIT_MISSING_CROSSING_VOLT_A_EN +: 2] = i_zx_missing; // RULE_13
    end

    // Effective enables: reserved and variant-inert bits never gate a request.
    always_comb begin
        ena_one = state_reg.mask_one & `MEIM_MASK_ONE_LIVE; // RULE_08
        if (!HAS_REACTIVE) begin
            ena_one[`MEIM_BIT_REVRP_A +: 3] = 3'h0; // RULE_09
        end
        ena_two = state_reg.mask_two & `MEIM_MASK_TWO_LIVE;
        if (!HAS_FUNDAMENTAL) begin
            ena_two[`MEIM_BIT_NO_LOAD_FUNDAMENTAL_EN] = 1'b0; // RULE_11
        end
    end

    assign irq_one_level = |(state_reg.status_one & ena_one); // RULE_15
    assign irq_two_level = |(state_reg.status_two & ena_two); // RULE_15

    // =================================================================
    // Register file and next state
    // =================================================================
    always_comb begin
        logic wr_one;
        logic wr_two;
        wr_one = i_write && (i_addr == `MEIM_OFF_STATUS_ONE);
        wr_two = i_write && (i_addr == `MEIM_OFF_STATUS_TWO);
        state_next = state_reg;
        state_next.tick_cnt = dsp_done ? 14'h0000 : state_reg.tick_cnt + 14'h0001;
        state_next.pulse = pulse_level;
        // Write-one-to-clear; a fresh event in the same cycle wins.
        state_next.status_one = ((state_reg.status_one & ~(wr_one ? i_wdata : '0)) | set_one);
        state_next.status_two = ((state_reg.status_two & ~(wr_two ? i_wdata : '0)) | set_two);
        state_next.irq_status = state_reg.irq_status | {irq_two_level, irq_one_level};
        if (i_write) begin
            case (i_addr)
                `MEIM_OFF_MASK_ONE: begin
                    state_next.mask_one = i_wdata & `MEIM_MASK_ONE_KEEP; // RULE_08 RULE_16
                end
                `MEIM_OFF_MASK_TWO: begin
                    state_next.mask_two = i_wdata; // RULE_16
                end
                `MEIM_OFF_ACCUMULATION_MODE_REG: begin
                    state_next.accumulation_mode_reg = i_wdata & `MEIM_ACCUMULATION_MODE_REG_KEEP;
                end
                `MEIM_OFF_PULSE_OUTPUT_CONFIG_REG: begin
                    state_next.pulse_output_config_reg = i_wdata & `MEIM_PULSE_OUTPUT_CONFIG_REG_KEEP;
                end
                `MEIM_OFF_IRQ_STATUS: begin
                    state_next.irq_status = (state_reg.irq_status & ~i_wdata[1:0])
                        | {irq_two_level, irq_one_level};
                end
                `MEIM_OFF_IRQ_MASK: begin
                    state_next.irq_mask = i_wdata[1:0];
                end
                default: begin
                end
            endcase
        end
        state_next.rdata = '0;
        if (i_read) begin
            case (i_addr)
                `MEIM_OFF_MASK_ONE: state_next.rdata = state_reg.mask_one; // RULE_16
                `MEIM_OFF_MASK_TWO: state_next.rdata = state_reg.mask_two; // RULE_16
                `MEIM_OFF_STATUS_ONE: state_next.rdata = state_reg.status_one;
                `MEIM_OFF_STATUS_TWO: state_next.rdata = state_reg.status_two;
                `MEIM_OFF_ACCUMULATION_MODE_REG: state_next.rdata = state_reg.accumulation_mode_reg;
                `MEIM_OFF_PULSE_OUTPUT_CONFIG_REG: state_next.rdata = state_reg.pulse_output_config_reg;
                `MEIM_OFF_IRQ_STATUS: state_next.rdata = {30'h0, state_reg.irq_status};
                `MEIM_OFF_IRQ_MASK: state_next.rdata = {30'h0, state_reg.irq_mask};
                default: state_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state_reg <= '0;
            state_reg.pulse_output_config_reg <= `MEIM_RST_PULSE_OUTPUT_CONFIG_REG;
            state_reg.pulse <= 3'h7;
        end else begin
            state_reg <= state_next;
        end
    end

    // =================================================================
    // Outputs
    // =================================================================
    // A pin with its configuration bit 9-11 clear is released; its event still sets the flag above.
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            o_pulse_out_oe[p] = state_reg.pulse_output_config_reg[`MEIM_BIT_PULSE_OUT_ONE_DISABLE + p]; // RULE_05
        end
    end

    assign o_pulse_out = state_reg.pulse;
    assign o_rdata = state_reg.rdata;
    assign o_irq_one = irq_one_level;
    assign o_irq_two = irq_two_level;
    assign o_irq = |(state_reg.irq_status & state_reg.irq_mask);
endmodule : meim_event_mask

`default_nettype wire

/* File: test/meim_event_mask_checker.sv */
// Purpose: Port-level assertions for the event mask block.
// Assumes: Mask registers are mirrored from writes on the register port.
// Notes: Bound to every instance of the block.
`include "meim_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module meim_event_mask_checker (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire meim_pkg::meim_addr_t i_addr,
    input wire meim_pkg::meim_word_t i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    input wire meim_pkg::meim_word_t o_rdata,
    input wire logic [2:0] i_no_load,
    input wire logic [1:0] i_zx_missing,
    input wire logic [2:0] o_pulse_out,
    input wire logic [2:0] o_pulse_out_oe,
    input wire logic o_irq_one,
    input wire logic o_irq_two,
    input wire logic o_irq
);
    import meim_pkg::*;
    meim_word_t m1_reg;
    meim_word_t m2_reg;
    logic [1:0] im_reg;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    // =====================================================================
    // Mirror of the mask registers
    // =====================================================================
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            m1_reg <= 32'h0;
            m2_reg <= 32'h0;
            im_reg <= 2'h0;
        end else if (i_write) begin
            if (i_addr == `MEIM_OFF_MASK_ONE) m1_reg <= i_wdata;
            if (i_addr == `MEIM_OFF_MASK_TWO) m2_reg <= i_wdata;
            if (i_addr == `MEIM_OFF_IRQ_MASK) im_reg <= i_wdata[1:0];
        end
    end
    // =====================================================================
    // Assertions
    // =====================================================================
    chk_rdata_idle: assert property (!$past(i_read) |-> o_rdata == 32'h0)
        else $error("read data not idle");
    chk_mask_two_rd: assert property (i_read && i_addr == `MEIM_OFF_MASK_TWO |=> o_rdata == m2_reg)
        else $error("mask two read back wrong");
    chk_mask_one_rd: assert property (i_read && i_addr == `MEIM_OFF_MASK_ONE |=> o_rdata == (m1_reg & 32'h0007ffff))
        else $error("mask one read back wrong");
    chk_zx_a_irq: assert property (i_zx_missing[0] && m2_reg[3] |=> o_irq_two)
        else $error("missing crossing gave no request");
    chk_no_load_irq: assert property (i_no_load[0] && m2_reg[0] |=> o_irq_two)
        else $error("no-load entry gave no request");
    chk_two_quiet: assert property ((m2_reg & 32'h0000001f) == 32'h0 |-> !o_irq_two)
        else $error("request two with all enables clear");
    chk_one_quiet: assert property ((m1_reg & 32'h0007fe00) == 32'h0 |-> !o_irq_one)
        else $error("request one with all enables clear");
    chk_pulse_fall: assert property ($fell(o_pulse_out[0]) && m1_reg[14] |-> ##[0:2] o_irq_one)
        else $error("pulse edge gave no request");
    chk_oe_cfg: assert property ($changed(o_pulse_out_oe) |-> $past(i_write) && $past(i_addr) == `MEIM_OFF_PULSE_OUTPUT_CONFIG_REG)
        else $error("pin enable moved without a write");
    chk_top_irq: assert property (o_irq_two && im_reg[1] |=> o_irq)
        else $error("summary request missing");
    cover property (o_irq);
    cover property ($fell(o_pulse_out[0]));
    cover property (o_irq_two && !o_irq_one);
endmodule : meim_event_mask_checker

bind meim_event_mask meim_event_mask_checker u_meim_event_mask_checker (.i_clock, .i_reset_n, .i_addr,
    .i_wdata, .i_write, .i_read, .o_rdata, .i_no_load, .i_zx_missing, .o_pulse_out, .o_pulse_out_oe,
    .o_irq_one, .o_irq_two, .o_irq);
`default_nettype wire

/* File: test/meim_event_mask_tb_top.sv */
// Purpose: Self-checking bench for the event mask block.
// Assumes: Computation period shortened to 20 cycles.
// Notes: All access goes through the word register port.
`include "meim_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module meim_event_mask_tb_top;
    import meim_pkg::*;
    logic i_clock, i_reset_n, i_write, i_read, o_irq_one, o_irq_two, o_irq;
    meim_addr_t i_addr;
    meim_word_t i_wdata, o_rdata, rd_val;
    logic [2:0] i_reactive_total, i_reactive_fund, o_pulse_out, o_pulse_out_oe;
    logic [7:0] i_power_sign, i_pulse_req;
    logic [4:0] ev_in;
    int errors, num_checks;
    meim_event_mask #(.DSP_CYCLES(20)) u_meim_event_mask (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
        .i_reactive_total(i_reactive_total), .i_reactive_fund(i_reactive_fund), .i_power_sign(i_power_sign),
        .i_pulse_req(i_pulse_req), .i_no_load(ev_in[2:0]), .i_zx_missing(ev_in[4:3]), .o_pulse_out(o_pulse_out),
        .o_pulse_out_oe(o_pulse_out_oe), .o_irq_one(o_irq_one), .o_irq_two(o_irq_two), .o_irq(o_irq));
    // =====================================================================
    // Access tasks
    // =====================================================================
    task automatic chk(input meim_word_t got, input meim_word_t exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input meim_addr_t a, input meim_word_t d);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
        @(posedge i_clock);
    endtask : wr
    task automatic rd(input meim_addr_t a);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1 rd_val = o_rdata;
        @(posedge i_clock);
    endtask : rd
    // Waits for the flag, checks it, then clears it by writing a one.
    task automatic ev(input meim_addr_t a, input int b);
        repeat (3) @(posedge i_clock);
        rd(a);
        chk({31'h0, rd_val[b]}, 32'h1);
        wr(a, 32'h1 << b);
    endtask : ev
    task automatic results;
        if (errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    initial begin
        repeat (5000) @(posedge i_clock);
        errors++;
        results();
    end
    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        {i_reset_n, i_write, i_read, i_addr, i_wdata} = '0;
        {i_reactive_total, i_reactive_fund, i_power_sign, i_pulse_req, ev_in} = '0;
        errors = 0;
        num_checks = 0;
        repeat (5) @(posedge i_clock);
        i_reset_n <= 1'b1;
        @(posedge i_clock);
        rd(`MEIM_OFF_MASK_ONE);
        chk(rd_val, 32'h0);
        rd(`MEIM_OFF_MASK_TWO);
        chk(rd_val, 32'h0);
        chk({29'h0, o_pulse_out_oe}, 32'h7);
        wr(`MEIM_OFF_MASK_ONE, 32'hffffffff);
        wr(`MEIM_OFF_MASK_TWO, 32'hffffffff);
        wr(16'h0001, 32'hffffffff);
        rd(`MEIM_OFF_MASK_ONE);
        chk(rd_val, 32'h0007ffff);
        rd(`MEIM_OFF_MASK_TWO);
        chk(rd_val, 32'hffffffff);
        rd(16'h0001);
        chk(rd_val, 32'h0);
        wr(`MEIM_OFF_IRQ_MASK, 32'h2);
        for (int k = 0; k < 5; k++) begin
            ev_in[k] <= 1'b1;
            @(posedge i_clock);
            ev_in <= 5'h0;
            @(negedge i_clock);
            chk({31'h0, o_irq_two}, 32'h1);
            ev(`MEIM_OFF_STATUS_TWO, k);
        end
        @(negedge i_clock);
        chk({31'h0, o_irq_two}, 32'h0);
        chk({31'h0, o_irq}, 32'h1);
        @(posedge i_clock);
        wr(`MEIM_OFF_IRQ_STATUS, 32'h2);
        wr(`MEIM_OFF_MASK_TWO, 32'h0);
        ev_in[4] <= 1'b1;
        @(posedge i_clock);
        ev_in <= 5'h0;
        repeat (2) @(negedge i_clock);
        chk({30'h0, o_irq_two, o_irq}, 32'h0);
        @(posedge i_clock);
        wr(`MEIM_OFF_MASK_TWO, 32'h10);
        @(negedge i_clock);
        chk({31'h0, o_irq_two}, 32'h1);
        @(posedge i_clock);
        ev(`MEIM_OFF_STATUS_TWO, 4);
        for (int k = 0; k < 3; k++) begin
            i_pulse_req[k] <= 1'b1;
            ev(`MEIM_OFF_STATUS_ONE, 14 + k);
            i_pulse_req[k] <= 1'b0;
        end
        // Pulse output one now follows quantity 5, and all pins are released.
        wr(`MEIM_OFF_PULSE_OUTPUT_CONFIG_REG, 32'h0000008d);
        i_pulse_req[5] <= 1'b1;
        ev(`MEIM_OFF_STATUS_ONE, 14);
        chk({26'h0, o_pulse_out_oe, o_pulse_out}, 32'h6);
        i_pulse_req[5] <= 1'b0;
        i_power_sign[5] <= 1'b1;
        ev(`MEIM_OFF_STATUS_ONE, 9);
        i_power_sign[1] <= 1'b1;
        ev(`MEIM_OFF_STATUS_ONE, 13);
        i_power_sign[2] <= 1'b1;
        ev(`MEIM_OFF_STATUS_ONE, 18);
        for (int k = 0; k < 3; k++) begin
            i_reactive_total[k] <= 1'b1;
            ev(`MEIM_OFF_STATUS_ONE, 10 + k);
        end
        wr(`MEIM_OFF_ACCUMULATION_MODE_REG, 32'h80);
        // Switching the source flips all three watched signs; check and clear those flags first.
        repeat (3) @(posedge i_clock);
        rd(`MEIM_OFF_STATUS_ONE);
        chk(rd_val & 32'h00001c00, 32'h00001c00);
        wr(`MEIM_OFF_STATUS_ONE, 32'h00001c00);
        for (int k = 0; k < 3; k++) begin
            i_reactive_fund[k] <= 1'b1;
            ev(`MEIM_OFF_STATUS_ONE, 10 + k);
        end
        @(negedge i_clock);
        chk({31'h0, o_irq_one}, 32'h1);
        @(posedge i_clock);
        wr(`MEIM_OFF_MASK_ONE, 32'h0);
        @(negedge i_clock);
        chk({31'h0, o_irq_one}, 32'h0);
        @(posedge i_clock);
        rd(`MEIM_OFF_STATUS_ONE);
        chk({31'h0, rd_val[17]}, 32'h1);
        wr(`MEIM_OFF_MASK_ONE, 32'h0007ffff);
        wr(`MEIM_OFF_STATUS_ONE, 32'h00020000);
        repeat (20) @(posedge i_clock);
        ev(`MEIM_OFF_STATUS_ONE, 17);
        results();
    end
endmodule : meim_event_mask_tb_top
`default_nettype wire
